// File: rtl/acdo_map.vh
// acdo_map.vh: register offsets, status bit positions, reset values and link constants
// assumes: included by the acceleration read-out design files and by the test host model
`ifndef ACDO_MAP_VH
`define ACDO_MAP_VH

// register offsets in the serial register space
`define ACDO_SAMPLE_STATUS 7'h00
`define ACDO_X_ACCEL_HIGH 7'h01
`define ACDO_X_ACCEL_LOW 7'h02
`define ACDO_Y_ACCEL_HIGH 7'h03
`define ACDO_Y_ACCEL_LOW 7'h04
`define ACDO_Z_ACCEL_HIGH 7'h05
`define ACDO_Z_ACCEL_LOW 7'h06
`define ACDO_PTR_LAST 7'h7f

// status byte bit positions
`define ACDO_ALL_OW_BIT 7
`define ACDO_Z_OW_BIT 6
`define ACDO_Y_OW_BIT 5
`define ACDO_X_OW_BIT 4
`define ACDO_ALL_RDY_BIT 3
`define ACDO_Z_RDY_BIT 2
`define ACDO_Y_RDY_BIT 1
`define ACDO_X_RDY_BIT 0

// reset values
`define ACDO_STATUS_RST 8'h00
`define ACDO_SAMPLE_RST 14'h0000
`define ACDO_READ_ZERO 8'h00

// buffer mode field value meaning disabled
`define ACDO_BUF_OFF 2'h0

// serial link: arbitrary default slave address, index of the last bit in a byte
`define ACDO_SLAVE_ADDR 7'h2a
`define ACDO_BIT_LAST 3'h7

`endif

// File: rtl/acdo_line_sync.v
// acdo_line_sync.v: samples the serial clock and data pins into the core clock domain
// assumes: scl and sda arrive asynchronously; clk is much faster than scl
`timescale 1ns/1ps
`default_nettype none

module acdo_line_sync (
  input wire clk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output reg scl_rise_ff,
  output reg scl_fall_ff,
  output reg sda_lvl_ff,
  output reg start_ff,
  output reg stop_ff
);

  reg [1:0] meta_ff;
  reg [1:0] sync_ff;
  reg [1:0] prev_ff;
  wire [1:0] pins;

  assign pins = {sda_in, scl_in};

  // two-flop synchroniser per line plus a history flop; the first stage feeds no logic
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sync
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta_ff[i] <= 1'b1;
          sync_ff[i] <= 1'b1;
          prev_ff[i] <= 1'b1;
        end else begin
          meta_ff[i] <= pins[i];
          sync_ff[i] <= meta_ff[i];
          prev_ff[i] <= sync_ff[i];
        end
      end
    end
  endgenerate

  // edge and bus-condition pulses, one clk wide; start/stop need scl high on both samples
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_rise_ff <= 1'b0;
      scl_fall_ff <= 1'b0;
      sda_lvl_ff <= 1'b1;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      scl_rise_ff <= sync_ff[0] & ~prev_ff[0];
      scl_fall_ff <= ~sync_ff[0] & prev_ff[0];
      sda_lvl_ff <= sync_ff[1];
      start_ff <= sync_ff[0] & prev_ff[0] & ~sync_ff[1] & prev_ff[1];
      stop_ff <= sync_ff[0] & prev_ff[0] & sync_ff[1] & ~prev_ff[1];
    end
  end

endmodule

`default_nettype wire

// File: rtl/acdo_readout.v
// acdo_readout.v: three-axis sample read-out with status flags behind a serial slave port
// assumes: sample and buffer inputs come from logic on clk; scl/sda are raw pins
`timescale 1ns/1ps
`default_nettype none
`include "acdo_map.vh"

module acdo_readout #(
  parameter [6:0] SLAVE_ADDR = `ACDO_SLAVE_ADDR
) (
  input wire clk,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_ff,
  input wire sample_strobe,
  input wire [2:0] sample_axes,
  input wire [13:0] x_sample,
  input wire [13:0] y_sample,
  input wire [13:0] z_sample,
  input wire [2:0] axis_enable,
  input wire [1:0] buf_mode,
  input wire fast_read,
  input wire [7:0] buf_status,
  input wire [13:0] buf_x,
  input wire [13:0] buf_y,
  input wire [13:0] buf_z,
  output reg buf_pop_ff,
  output reg [7:0] sample_status_ff
);

  // serial slave states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV = 3'd1;
  localparam [2:0] ST_DACK = 3'd2;
  localparam [2:0] ST_PTR = 3'd3;
  localparam [2:0] ST_PACK = 3'd4;
  localparam [2:0] ST_RD = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;
  localparam [2:0] ST_WIGN = 3'd7;

  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire start_det;
  wire stop_det;

  acdo_line_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .scl_in(scl),
    .sda_in(sda_in),
    .scl_rise_ff(scl_rise),
    .scl_fall_ff(scl_fall),
    .sda_lvl_ff(sda_lvl),
    .start_ff(start_det),
    .stop_ff(stop_det)
  );

  reg [2:0] state_ff, nxt_state;
  reg [2:0] cnt_ff, nxt_cnt;
  reg [7:0] sh_ff, nxt_sh;
  reg [6:0] ptr_ff, nxt_ptr;
  reg is_read_ff, nxt_is_read;
  reg nxt_oe;
  reg [7:0] low_latch_ff, nxt_low_latch;
  reg nxt_pop;
  reg load;

  reg [13:0] axis_ff [0:2];
  reg [2:0] rdy_ff;
  reg [2:0] ow_ff;
  reg [2:0] pend_ff;
  reg all_rdy_ff, nxt_all_rdy;
  reg all_ow_ff, nxt_all_ow;
  wire [2:0] new_axis;
  wire [2:0] hi_read;
  wire [2:0] nxt_pend;
  wire buf_on;

  // one-hot axis selected when the given address is a high-byte register
  function [2:0] hi_axis;
    input [6:0] addr;
    begin
      case (addr)
        `ACDO_X_ACCEL_HIGH: hi_axis = 3'h1;
        `ACDO_Y_ACCEL_HIGH: hi_axis = 3'h2;
        `ACDO_Z_ACCEL_HIGH: hi_axis = 3'h4;
        default: hi_axis = 3'h0;
      endcase
    end
  endfunction

  // next burst address; low bytes are skipped in fast mode, data wraps per buffer mode
  function [6:0] next_ptr;
    input [6:0] addr;
    input fast;
    input bufon;
    begin
      if (addr == `ACDO_SAMPLE_STATUS) begin
        next_ptr = `ACDO_X_ACCEL_HIGH;
      end else if (fast && hi_axis(addr) != 3'h0) begin
        if (addr == `ACDO_Z_ACCEL_HIGH) begin
          next_ptr = bufon ? `ACDO_X_ACCEL_HIGH : `ACDO_SAMPLE_STATUS;
        end else begin
          next_ptr = addr + 7'h02;
        end
      end else if (addr == `ACDO_Z_ACCEL_LOW) begin
        next_ptr = bufon ? `ACDO_X_ACCEL_HIGH : `ACDO_SAMPLE_STATUS;
      end else if (addr == `ACDO_PTR_LAST) begin
        next_ptr = `ACDO_SAMPLE_STATUS;
      end else begin
        next_ptr = addr + 7'h01;
      end
    end
  endfunction

  assign buf_on = (buf_mode != `ACDO_BUF_OFF);
  assign new_axis = sample_axes & {3{sample_strobe}};
  // flags belong to live data only; reads of the buffer head leave them alone
  assign hi_read = (load && !buf_on) ? hi_axis(ptr_ff) : 3'h0;

  // live sample holding registers, one per axis
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_axis
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          axis_ff[i] <= `ACDO_SAMPLE_RST;
          rdy_ff[i] <= 1'b0;
          ow_ff[i] <= 1'b0;
          pend_ff[i] <= 1'b0;
        end else begin
          if (new_axis[i]) begin
            axis_ff[i] <= (i == 0) ? x_sample : ((i == 1) ? y_sample : z_sample);
          end
          // a sample arriving with the clearing read wins over the clear
          if (new_axis[i]) begin
            rdy_ff[i] <= 1'b1;
          end else if (hi_read[i]) begin
            rdy_ff[i] <= 1'b0;
          end
          if (new_axis[i] && rdy_ff[i]) begin
            ow_ff[i] <= 1'b1;
          end else if (hi_read[i]) begin
            ow_ff[i] <= 1'b0;
          end
          pend_ff[i] <= nxt_pend[i];
        end
      end
      // pending bit: enabled axis with data not yet fetched by its high byte
      assign nxt_pend[i] = (new_axis[i] & axis_enable[i]) | (pend_ff[i] & ~hi_read[i]);
    end
  endgenerate

  // combined flags clear only when every enabled axis has had its high byte read
  always @* begin
    nxt_all_rdy = all_rdy_ff;
    nxt_all_ow = all_ow_ff;
    if ((|hi_read) && (nxt_pend == 3'h0)) begin
      nxt_all_rdy = 1'b0;
      nxt_all_ow = 1'b0;
    end
    if (|(new_axis & axis_enable)) begin
      nxt_all_rdy = 1'b1;
    end
    if (|(new_axis & rdy_ff)) begin
      nxt_all_ow = 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      all_rdy_ff <= 1'b0;
      all_ow_ff <= 1'b0;
    end else begin
      all_rdy_ff <= nxt_all_rdy;
      all_ow_ff <= nxt_all_ow;
    end
  end

  // byte returned for the current address; low bytes come from the latch only
  reg [7:0] rd_byte;
  reg [13:0] sel_word;
  always @* begin
    case (ptr_ff)
      `ACDO_X_ACCEL_HIGH, `ACDO_X_ACCEL_LOW: sel_word = buf_on ? buf_x : axis_ff[0];
      `ACDO_Y_ACCEL_HIGH, `ACDO_Y_ACCEL_LOW: sel_word = buf_on ? buf_y : axis_ff[1];
      `ACDO_Z_ACCEL_HIGH, `ACDO_Z_ACCEL_LOW: sel_word = buf_on ? buf_z : axis_ff[2];
      default: sel_word = `ACDO_SAMPLE_RST;
    endcase
    case (ptr_ff)
      `ACDO_SAMPLE_STATUS: rd_byte = buf_on ? buf_status : sample_status_ff;
      `ACDO_X_ACCEL_HIGH, `ACDO_Y_ACCEL_HIGH, `ACDO_Z_ACCEL_HIGH: rd_byte = sel_word[13:6];
      `ACDO_X_ACCEL_LOW, `ACDO_Y_ACCEL_LOW, `ACDO_Z_ACCEL_LOW: rd_byte = low_latch_ff;
      default: rd_byte = `ACDO_READ_ZERO;
    endcase
  end

  // live status byte, registered so address zero reads a stable value
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_status_ff <= `ACDO_STATUS_RST;
    end else begin
      sample_status_ff[`ACDO_ALL_OW_BIT] <= nxt_all_ow;
      sample_status_ff[`ACDO_Z_OW_BIT] <= ow_ff[2];
      sample_status_ff[`ACDO_Y_OW_BIT] <= ow_ff[1];
      sample_status_ff[`ACDO_X_OW_BIT] <= ow_ff[0];
      sample_status_ff[`ACDO_ALL_RDY_BIT] <= nxt_all_rdy;
      sample_status_ff[`ACDO_Z_RDY_BIT] <= rdy_ff[2];
      sample_status_ff[`ACDO_Y_RDY_BIT] <= rdy_ff[1];
      sample_status_ff[`ACDO_X_RDY_BIT] <= rdy_ff[0];
    end
  end

  // serial slave: bits taken on scl rise, driven on scl fall
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_is_read = is_read_ff;
    nxt_oe = sda_oe_ff;
    nxt_low_latch = low_latch_ff;
    nxt_pop = 1'b0;
    load = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_oe = 1'b0;
      end
      ST_DEV, ST_PTR, ST_WIGN: begin
        if (scl_rise) begin
          nxt_sh = {sh_ff[6:0], sda_lvl};
          nxt_cnt = cnt_ff + 3'h1;
        end else if (scl_fall && cnt_ff == 3'h0 && sh_ff != 8'h00 && state_ff == ST_DEV) begin
          // eighth bit has been taken: decide on the address
          if (sh_ff[7:1] == SLAVE_ADDR) begin
            nxt_is_read = sh_ff[0];
            nxt_oe = 1'b1;
            nxt_state = ST_DACK;
          end else begin
            nxt_state = ST_IDLE;
          end
        end else if (scl_fall && cnt_ff == 3'h0 && state_ff != ST_DEV) begin
          if (state_ff == ST_PTR) begin
            nxt_ptr = sh_ff[6:0];
          end
          nxt_oe = 1'b1;
          nxt_state = ST_PACK;
        end
      end
      ST_DACK: begin
        if (scl_fall) begin
          nxt_oe = 1'b0;
          nxt_cnt = 3'h0;
          nxt_sh = 8'h00;
          if (is_read_ff) begin
            load = 1'b1;
            nxt_state = ST_RD;
          end else begin
            nxt_state = ST_PTR;
          end
        end
      end
      ST_PACK: begin
        // write data past the address byte is acknowledged and dropped
        if (scl_fall) begin
          nxt_oe = 1'b0;
          nxt_cnt = 3'h0;
          nxt_sh = 8'h00;
          nxt_state = ST_WIGN;
        end
      end
      ST_RD: begin
        if (scl_fall) begin
          if (cnt_ff == `ACDO_BIT_LAST) begin
            nxt_oe = 1'b0;
            nxt_state = ST_RACK;
          end else begin
            nxt_oe = ~sh_ff[7];
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_cnt = cnt_ff + 3'h1;
          end
        end
      end
      ST_RACK: begin
        // host nack ends the burst; ack asks for the next byte
        if (scl_rise && sda_lvl) begin
          nxt_state = ST_IDLE;
        end else if (scl_fall) begin
          load = 1'b1;
          nxt_state = ST_RD;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
    // a byte is fetched: drive its msb, apply read side effects, step the address
    if (load) begin
      nxt_oe = ~rd_byte[7];
      nxt_sh = {rd_byte[6:0], 1'b0};
      nxt_cnt = 3'h0;
      nxt_ptr = next_ptr(ptr_ff, fast_read, buf_on);
      if (hi_axis(ptr_ff) != 3'h0) begin
        nxt_low_latch = {sel_word[5:0], 2'b00};
      end
      if (buf_on && (ptr_ff == `ACDO_Z_ACCEL_LOW || (fast_read && ptr_ff == `ACDO_Z_ACCEL_HIGH))) begin
        nxt_pop = 1'b1;
      end
    end
    if (start_det) begin
      nxt_state = ST_DEV;
      nxt_cnt = 3'h0;
      nxt_sh = 8'h00;
      nxt_oe = 1'b0;
      load = 1'b0;
      nxt_pop = 1'b0;
    end
    if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_ptr = `ACDO_SAMPLE_STATUS;
      nxt_oe = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      sh_ff <= 8'h00;
      ptr_ff <= `ACDO_SAMPLE_STATUS;
      is_read_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      low_latch_ff <= `ACDO_READ_ZERO;
      buf_pop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      is_read_ff <= nxt_is_read;
      sda_oe_ff <= nxt_oe;
      sda_out_ff <= 1'b0; // open drain: only ever pulls low
      low_latch_ff <= nxt_low_latch;
      buf_pop_ff <= nxt_pop;
    end
  end

endmodule

`default_nettype wire

// File: test/acdo_host.sv
// acdo_host.sv: serial bus master model that reads the acceleration read-out block
// assumes: sda is a pulled-up wire; this model only ever pulls it low
`timescale 1ns/1ps
`default_nettype none
`include "acdo_map.vh"

module acdo_host #(
  parameter real QTR = 31.25
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  logic [7:0] got [0:7];
  logic [7:0] nak = 8'h00;
  logic r;
  // clock rests high between frames, as a pulled-up bus does
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves mid-low and is sampled mid-high, four quarters make 125 ns
  task automatic bit_x(input logic b, output logic s);
    #QTR sda_low = ~b;
    #QTR scl = 1'b1;
    #QTR s = sda;
    #QTR scl = 1'b0;
  endtask
  task automatic start();
    #QTR sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
  endtask
  task automatic stop();
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask
  // ninth bit carries the acknowledge; a missing one is counted
  task automatic wbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    if (r) nak++;
  endtask
  task automatic set_ptr(input logic [6:0] p);
    start();
    wbyte({`ACDO_SLAVE_ADDR, 1'b0});
    wbyte({1'b0, p});
  endtask
  // reads only walk forward, so a low byte always follows its own high byte
  task automatic rd(input int n);
    start();
    wbyte({`ACDO_SLAVE_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) bit_x(1'b1, got[i][j]);
      bit_x(i == n - 1, r);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: test/acdo_readout_chk.sv
// acdo_readout_chk.sv: status flag and buffer pop checks on the read-out ports
// assumes: bound into acdo_readout; one clock domain
`timescale 1ns/1ps
`default_nettype none

module acdo_readout_chk (
  input wire clk,
  input wire nrst,
  input wire scl,
  input wire sample_strobe,
  input wire [2:0] sample_axes,
  input wire [2:0] axis_enable,
  input wire [1:0] buf_mode,
  input wire buf_pop_ff,
  input wire [7:0] sample_status_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  rdy_set_a: assert property (sample_strobe && sample_axes[0] |-> ##[1:3] sample_status_ff[0])
    else $error("x ready not raised");
  all_rdy_set_a: assert property (sample_strobe && |(sample_axes & axis_enable) |-> ##[1:3] sample_status_ff[3])
    else $error("combined ready not raised");
  // scl held high keeps a fetch from racing the strobe
  ow_set_a: assert property (sample_strobe && sample_axes[1] && sample_status_ff[1] && scl && $past(scl, 4)
    |-> ##[1:3] (sample_status_ff[5] && sample_status_ff[7])) else $error("overwrite not raised");
  rdy_cause_a: assert property ($rose(sample_status_ff[0]) |-> $past(sample_strobe, 2) && $past(sample_axes[0], 2))
    else $error("x ready rose without sample");
  // the combined bit is registered one cycle ahead of the per-axis copies, so look one cycle on
  ow_cause_a: assert property ($rose(sample_status_ff[7]) |=> |sample_status_ff[6:4])
    else $error("combined overwrite without axis overwrite");
  rdy_clear_a: assert property ($fell(sample_status_ff[0]) |-> $past(buf_mode, 2) == 2'h0)
    else $error("x ready cleared with buffer on");
  all_rdy_clear_a: assert property ($fell(sample_status_ff[3]) |=> (sample_status_ff[2:0] & axis_enable) == 3'h0)
    else $error("combined ready cleared early");
  all_ow_clear_a: assert property ($fell(sample_status_ff[7]) |=> (sample_status_ff[2:0] & axis_enable) == 3'h0)
    else $error("combined overwrite cleared early");
  pop_pulse_a: assert property (buf_pop_ff |=> !buf_pop_ff)
    else $error("pop longer than one cycle");
  pop_mode_a: assert property (buf_pop_ff |-> $past(buf_mode) != 2'h0)
    else $error("pop with buffer off");
endmodule

bind acdo_readout acdo_readout_chk u_acdo_readout_chk (.clk(clk), .nrst(nrst), .scl(scl),
  .sample_strobe(sample_strobe), .sample_axes(sample_axes), .axis_enable(axis_enable),
  .buf_mode(buf_mode), .buf_pop_ff(buf_pop_ff), .sample_status_ff(sample_status_ff));
`default_nettype wire

// File: test/acdo_readout_bench.sv
// acdo_readout_bench.sv: self-checking bench for the acceleration read-out block
// assumes: acdo_host drives the serial pins; bench drives samples 1 ns after clk rises
`timescale 1ns/1ps
`default_nettype none

module acdo_readout_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic strobe = 1'b0;
  logic [2:0] axes = 3'h0;
  logic [13:0] smp [0:2] = '{14'h2abc, 14'h0155, 14'h3ffc};
  logic [13:0] bs [0:2] = '{14'h1234, 14'h3e01, 14'h0fc0};
  logic [2:0] en = 3'h7;
  logic [1:0] mode = 2'h0;
  logic fast = 1'b0;
  logic [7:0] bst = 8'h00;
  wire scl;
  wire sda_low;
  wire sda_out;
  wire sda_oe;
  wire pop;
  wire [7:0] stat;
  // open drain: either side pulls low, else the pull-up wins
  wire sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int pops = 0;

  always #5 clk = ~clk;

  acdo_readout u_acdo_readout (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out_ff(sda_out),
    .sda_oe_ff(sda_oe), .sample_strobe(strobe), .sample_axes(axes), .x_sample(smp[0]), .y_sample(smp[1]),
    .z_sample(smp[2]), .axis_enable(en), .buf_mode(mode), .fast_read(fast), .buf_status(bst),
    .buf_x(bs[0]), .buf_y(bs[1]), .buf_z(bs[2]), .buf_pop_ff(pop), .sample_status_ff(stat));
  acdo_host u_acdo_host (.scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] hl(input logic [13:0] v);
    return {v[13:6], v[5:0], 2'h0};
  endfunction
  // one-cycle strobe, then let flags and status settle
  task automatic put(input logic [2:0] a);
    @(posedge clk);
    #1;
    axes = a;
    strobe = 1'b1;
    @(posedge clk);
    #1;
    strobe = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // pointer 8'hff skips the pointer write, so the read starts wherever stop left it
  task automatic burst(input logic [7:0] p, input int n, input logic [63:0] e);
    if (p != 8'hff) u_acdo_host.set_ptr(p[6:0]);
    u_acdo_host.rd(n);
    for (int i = 0; i < n; i++) chk(u_acdo_host.got[i], e[8*(n-1-i) +: 8]);
    @(posedge clk);
    #1;
  endtask

  task automatic t_full();
    put(3'h7);
    chk(stat, 8'h0f);
    burst(8'hff, 8, {8'h0f, hl(smp[0]), hl(smp[1]), hl(smp[2]), 8'h00});
    chk(stat, 8'h00);
  endtask
  task automatic t_ow();
    put(3'h7);
    put(3'h7);
    chk(stat, 8'hff);
    burst(8'h01, 1, smp[0][13:6]);
    chk(stat, 8'hee);
    burst(8'h03, 3, {hl(smp[1]), smp[2][13:6]});
    chk(stat, 8'h00);
  endtask
  task automatic t_enable();
    en = 3'h1;
    put(3'h7);
    burst(8'h01, 1, smp[0][13:6]);
    chk(stat, 8'h06);
    en = 3'h7;
    burst(8'h03, 3, {hl(smp[1]), smp[2][13:6]});
    chk(stat, 8'h00);
  endtask
  // a new x sample lands between the high and low fetches
  task automatic t_pair();
    logic [13:0] old;
    old = smp[0];
    put(3'h7);
    u_acdo_host.set_ptr(7'h01);
    fork
      u_acdo_host.rd(2);
      begin
        #1600;
        @(posedge clk);
        #1;
        smp[0] = ~old;
        put(3'h1);
      end
    join
    chk(u_acdo_host.got[0], old[13:6]);
    chk(u_acdo_host.got[1], {old[5:0], 2'h0});
    @(posedge clk);
    #1;
    burst(8'h01, 6, {hl(smp[0]), hl(smp[1]), hl(smp[2])});
    chk(stat, 8'h00);
  endtask
  task automatic t_fast();
    fast = 1'b1;
    put(3'h7);
    burst(8'hff, 5, {8'h0f, smp[0][13:6], smp[1][13:6], smp[2][13:6], 8'h00});
    fast = 1'b0;
  endtask
  task automatic t_buf();
    for (int m = 1; m < 4; m++) begin
      mode = m[1:0];
      bst = 8'h80 | m[7:0];
      burst(8'hff, 1, bst);
      burst(8'h01, 7, {hl(bs[0]), hl(bs[1]), hl(bs[2]), bs[0][13:6]});
    end
    // fast read with the buffer on wraps to the x high byte and pops on z high
    fast = 1'b1;
    burst(8'h01, 4, {bs[0][13:6], bs[1][13:6], bs[2][13:6], bs[0][13:6]});
    fast = 1'b0;
    chk(pops[7:0], 8'h04);
    mode = 2'h0;
    burst(8'hff, 1, 8'h00);
  endtask

  // hang guard, far above the expected run of about 11400 cycles
  always @(posedge clk) begin
    cyc++;
    if (pop === 1'b1) pops++;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(stat, 8'h00);
    burst(8'hff, 1, 8'h00);
    t_full();
    t_ow();
    t_enable();
    t_pair();
    t_fast();
    t_buf();
    chk(u_acdo_host.nak, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
